// ===== bas_map.svh
// bas_map.svh: register offsets, field positions and cycle counts of the bit/string unit
// assumes: included by its bare name from the bas design files
`ifndef BAS_MAP_SVH
`define BAS_MAP_SVH

// register byte offsets
`define BAS_CTRL_OFF 8'h00
`define BAS_OPER_OFF 8'h04
`define BAS_ACC_OFF 8'h08
`define BAS_CNT_OFF 8'h0C
`define BAS_FLAG_OFF 8'h10
`define BAS_PC_OFF 8'h14
`define BAS_STAT_OFF 8'h18
`define BAS_CYC_OFF 8'h1C

// control fields
`define BAS_CTRL_START 0
`define BAS_CTRL_OP_LSB 1
`define BAS_CTRL_OP_MSB 4
`define BAS_CTRL_FORM_LSB 5
`define BAS_CTRL_FORM_MSB 6
`define BAS_CTRL_WORD 7

// operand fields
`define BAS_OPER_ADDR_MSB 15
`define BAS_OPER_BP_LSB 16
`define BAS_OPER_BP_MSB 18
`define BAS_OPER_REL_LSB 24

// reset values
`define BAS_ACC_RST 32'h0000_0000
`define BAS_CNT_RST 16'h0000
`define BAS_PC_RST 16'h0000

// machine-cycle counts
`define BAS_CYC_LD 20'h00005
`define BAS_CYC_LD_IO 20'h00004
`define BAS_CYC_ST 20'h00007
`define BAS_CYC_ST_IO 20'h00006
`define BAS_CYC_SETCLR 20'h00007
`define BAS_CYC_BR_T 20'h00008
`define BAS_CYC_BR_N 20'h00007
`define BAS_CYC_BRIO_T 20'h00007
`define BAS_CYC_BRIO_N 20'h00006
`define BAS_CYC_TSB_T 20'h0000A
`define BAS_CYC_TSB_N 20'h00009
`define BAS_CYC_SWAP 20'h00002
`define BAS_CYC_STR_ZERO 20'h00005
`define BAS_CYC_STR_BASE 20'h00004
`define BAS_CYC_MOVE_EL 20'h00008
`define BAS_CYC_SRCH_EL 20'h00007
`define BAS_CYC_MATCH_END 20'h00005
`define BAS_CYC_FILL_EL 20'h00006
`define BAS_CYC_FILL_BASE 20'h00006

`endif

// ===== bas_pkg.sv
// bas_pkg.sv: types of the bit/accumulator/string execution unit
// assumes: compiled before the bas design modules
package bas_pkg;

  typedef enum logic [3:0] {
    BAS_BIT_MOVE_LD = 4'h0,
    BAS_BIT_MOVE_ST = 4'h1,
    BAS_BIT_SET_OP = 4'h2,
    BAS_BIT_CLEAR_OP = 4'h3,
    BAS_BRANCH_ON_BIT_LOW = 4'h4,
    BAS_BRANCH_ON_BIT_HIGH = 4'h5,
    BAS_TEST_AND_SET_BRANCH = 4'h6,
    BAS_WAIT_BIT_HIGH = 4'h7,
    BAS_WAIT_BIT_LOW = 4'h8,
    BAS_ACC_HALF_EXCHANGE = 4'h9,
    BAS_BLOCK_MOVE = 4'hA,
    BAS_BLOCK_MOVE_DOWN = 4'hB,
    BAS_BLOCK_SEARCH = 4'hC,
    BAS_BLOCK_SEARCH_DOWN = 4'hD,
    BAS_BLOCK_FILL = 4'hE,
    BAS_OP_NONE = 4'hF
  } bas_op_t;

  typedef enum logic [1:0] {
    BAS_FORM_DIR = 2'h0,
    BAS_FORM_ABS = 2'h1,
    BAS_FORM_IO = 2'h2,
    BAS_FORM_RSV = 2'h3
  } bas_form_t;

  typedef enum logic [2:0] {
    BAS_ST_IDLE = 3'h0,
    BAS_ST_RD = 3'h1,
    BAS_ST_EXE = 3'h2,
    BAS_ST_WR = 3'h3,
    BAS_ST_EL = 3'h4,
    BAS_ST_PAD = 3'h5
  } bas_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic io;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bas_mem_req_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bas_flags_t;

endpackage : bas_pkg

// ===== bas_tick.sv
// bas_tick.sv: machine-cycle enable divider
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module bas_tick #(
  parameter int unsigned DIV = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic tick
);

  logic [15:0] cnt_q;

  assign tick = (cnt_q == 16'(DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n || tick) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule : bas_tick

`default_nettype wire

// ===== bas_exec.sv
// bas_exec.sv: bit manipulation, accumulator half exchange and block string execution unit
// assumes: AHB-Lite single-word access from software; a memory/I/O port with req/ack handshake
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "bas_map.svh"

module bas_exec #(
  parameter int unsigned MCLK_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output bas_pkg::bas_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic tick;
  bas_pkg::bas_state_t st_q;
  bas_pkg::bas_op_t op_q;
  bas_pkg::bas_form_t form_q;
  bas_pkg::bas_flags_t flags_q;
  logic word_q;
  logic [31:0] oper_q;
  logic [31:0] acc_q;
  logic [15:0] cnt_q;
  logic [15:0] pc_q;
  logic [15:0] data_q;
  logic [15:0] m_q;
  logic [15:0] n_q;
  logic [19:0] cyc_q;
  logic [19:0] last_cyc_q;
  logic branch_q;
  logic match_q;
  logic ack_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;

  bas_tick #(.DIV(MCLK_DIV)) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic addr_ph;
  logic start;
  logic sw_wr_acc;
  logic sw_wr_cnt;
  logic sw_wr_flag;
  logic sw_wr_pc;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign addr_ph = hsel && htrans[1] && hready;
  assign start = wr_pend_q && (wr_addr_q == `BAS_CTRL_OFF) && hwdata[`BAS_CTRL_START]
                 && (st_q == bas_pkg::BAS_ST_IDLE);
  assign sw_wr_acc = wr_pend_q && (wr_addr_q == `BAS_ACC_OFF);
  assign sw_wr_cnt = wr_pend_q && (wr_addr_q == `BAS_CNT_OFF);
  assign sw_wr_flag = wr_pend_q && (wr_addr_q == `BAS_FLAG_OFF);
  assign sw_wr_pc = wr_pend_q && (wr_addr_q == `BAS_PC_OFF);
  assign busy = (st_q != bas_pkg::BAS_ST_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      wr_addr_q <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ph && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        `BAS_CTRL_OFF: rdata_q <= {24'h00_0000, word_q, form_q, op_q, busy};
        `BAS_OPER_OFF: rdata_q <= oper_q;
        `BAS_ACC_OFF: rdata_q <= acc_q;
        `BAS_CNT_OFF: rdata_q <= {16'h0000, cnt_q};
        `BAS_FLAG_OFF: rdata_q <= {28'h000_0000, flags_q};
        `BAS_PC_OFF: rdata_q <= {16'h0000, pc_q};
        `BAS_STAT_OFF: rdata_q <= {29'h0000_0000, match_q, branch_q, busy};
        `BAS_CYC_OFF: rdata_q <= {12'h000, last_cyc_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oper_q <= 32'h0000_0000;
      op_q <= bas_pkg::BAS_OP_NONE;
      form_q <= bas_pkg::BAS_FORM_DIR;
      word_q <= 1'b0;
    end else if (wr_pend_q && !busy) begin
      if (wr_addr_q == `BAS_OPER_OFF) begin
        oper_q <= hwdata;
      end
      if (wr_addr_q == `BAS_CTRL_OFF) begin
        op_q <= bas_pkg::bas_op_t'(hwdata[`BAS_CTRL_OP_MSB:`BAS_CTRL_OP_LSB]);
        form_q <= bas_pkg::bas_form_t'(hwdata[`BAS_CTRL_FORM_MSB:`BAS_CTRL_FORM_LSB]);
        word_q <= hwdata[`BAS_CTRL_WORD];
      end
    end
  end

  // ---------------------------------------------------------------
  // operand decode
  // ---------------------------------------------------------------
  bas_pkg::bas_op_t op_go;
  logic is_io;
  logic [2:0] bp;
  logic bit_val;
  logic [7:0] bit_mask;
  logic is_str;
  logic is_down;
  logic is_srch;
  logic [15:0] step;
  logic [15:0] al;
  logic [15:0] ah;
  logic [15:0] elem_a;
  logic [15:0] elem_b;
  logic [16:0] diff;
  logic [3:0] msb;
  logic hit;

  assign op_go = start ? bas_pkg::bas_op_t'(hwdata[`BAS_CTRL_OP_MSB:`BAS_CTRL_OP_LSB]) : op_q;
  assign is_io = (form_q == bas_pkg::BAS_FORM_IO);
  assign bp = oper_q[`BAS_OPER_BP_MSB:`BAS_OPER_BP_LSB];
  assign bit_mask = 8'h01 << bp;
  assign bit_val = |(data_q[7:0] & bit_mask);
  assign is_str = (op_q >= bas_pkg::BAS_BLOCK_MOVE) && (op_q <= bas_pkg::BAS_BLOCK_FILL);
  assign is_down = (op_q == bas_pkg::BAS_BLOCK_MOVE_DOWN)
                   || (op_q == bas_pkg::BAS_BLOCK_SEARCH_DOWN);
  assign is_srch = (op_q == bas_pkg::BAS_BLOCK_SEARCH) || (op_q == bas_pkg::BAS_BLOCK_SEARCH_DOWN);
  assign step = word_q ? 16'h0002 : 16'h0001;
  assign al = acc_q[15:0];
  assign ah = acc_q[31:16];
  // compare element minus lower half, at element width
  assign elem_a = word_q ? data_q : {8'h00, data_q[7:0]};
  assign elem_b = word_q ? al : {8'h00, al[7:0]};
  assign diff = {1'b0, elem_a} - {1'b0, elem_b};
  assign msb = word_q ? 4'hF : 4'h7;
  assign hit = word_q ? (diff[15:0] == 16'h0000) : (diff[7:0] == 8'h00);

  // ---------------------------------------------------------------
  // memory request
  // ---------------------------------------------------------------
  logic waiting;

  always_comb begin
    mem_req = '0;
    mem_req.req = (st_q == bas_pkg::BAS_ST_RD) || (st_q == bas_pkg::BAS_ST_WR);
    mem_req.we = (st_q == bas_pkg::BAS_ST_WR);
    mem_req.io = is_io && !is_str;
    mem_req.word = is_str && word_q;
    if (!is_str) begin
      mem_req.addr = is_io ? {8'h00, oper_q[7:0]} : oper_q[`BAS_OPER_ADDR_MSB:0];
      mem_req.wdata = data_q;
    end else if (op_q == bas_pkg::BAS_BLOCK_FILL) begin
      mem_req.addr = ah;
      mem_req.wdata = al;
    end else begin
      // move reads the source at the lower half, everything else uses the upper half
      mem_req.addr = (!is_srch && st_q == bas_pkg::BAS_ST_RD) ? al : ah;
      mem_req.wdata = data_q;
    end
  end

  assign waiting = mem_req.req && !(ack_q || mem_ack);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (mem_req.req && mem_ack && !tick) begin
      ack_q <= 1'b1;
    end else if (tick) begin
      ack_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // cycle target
  // ---------------------------------------------------------------
  logic [19:0] target;
  logic [19:0] m20;
  logic [19:0] n20;

  assign m20 = {4'h0, m_q};
  assign n20 = {4'h0, n_q};

  always_comb begin
    target = 20'h00001;
    case (op_q)
      bas_pkg::BAS_BIT_MOVE_LD: target = is_io ? `BAS_CYC_LD_IO : `BAS_CYC_LD;
      bas_pkg::BAS_BIT_MOVE_ST: target = is_io ? `BAS_CYC_ST_IO : `BAS_CYC_ST;
      bas_pkg::BAS_BIT_SET_OP, bas_pkg::BAS_BIT_CLEAR_OP: target = `BAS_CYC_SETCLR;
      bas_pkg::BAS_BRANCH_ON_BIT_LOW, bas_pkg::BAS_BRANCH_ON_BIT_HIGH: begin
        if (is_io) begin
          target = branch_q ? `BAS_CYC_BRIO_T : `BAS_CYC_BRIO_N;
        end else begin
          target = branch_q ? `BAS_CYC_BR_T : `BAS_CYC_BR_N;
        end
      end
      bas_pkg::BAS_TEST_AND_SET_BRANCH: target = branch_q ? `BAS_CYC_TSB_T : `BAS_CYC_TSB_N;
      bas_pkg::BAS_ACC_HALF_EXCHANGE: target = `BAS_CYC_SWAP;
      bas_pkg::BAS_BLOCK_MOVE, bas_pkg::BAS_BLOCK_MOVE_DOWN: begin
        target = (m_q == 16'h0000) ? `BAS_CYC_STR_ZERO
                 : 20'(`BAS_CYC_STR_BASE + `BAS_CYC_MOVE_EL * m20);
      end
      bas_pkg::BAS_BLOCK_SEARCH, bas_pkg::BAS_BLOCK_SEARCH_DOWN: begin
        if (m_q == 16'h0000) begin
          target = `BAS_CYC_STR_ZERO;
        end else if (match_q) begin
          target = 20'(`BAS_CYC_SRCH_EL * n20 + `BAS_CYC_MATCH_END);
        end else begin
          target = 20'(`BAS_CYC_STR_BASE + `BAS_CYC_SRCH_EL * m20);
        end
      end
      bas_pkg::BAS_BLOCK_FILL: target = 20'(`BAS_CYC_FILL_EL * m20 + `BAS_CYC_FILL_BASE);
      default: target = 20'h00001;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cyc_q <= 20'h00000;
      last_cyc_q <= 20'h00000;
    end else if (start) begin
      cyc_q <= 20'h00000;
    end else if (busy && tick && !waiting) begin
      cyc_q <= cyc_q + 20'h00001;
      if (st_q == bas_pkg::BAS_ST_PAD) begin
        last_cyc_q <= cyc_q + 20'h00001;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  logic adv;
  logic cnt_last;

  assign adv = tick && !waiting;
  assign cnt_last = (cnt_q == 16'h0001);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= bas_pkg::BAS_ST_IDLE;
      data_q <= 16'h0000;
      m_q <= 16'h0000;
      n_q <= 16'h0000;
      branch_q <= 1'b0;
      match_q <= 1'b0;
    end else if (start) begin
      m_q <= cnt_q;
      n_q <= 16'h0000;
      branch_q <= 1'b0;
      match_q <= 1'b0;
      if (op_go == bas_pkg::BAS_ACC_HALF_EXCHANGE) begin
        st_q <= bas_pkg::BAS_ST_EXE;
      end else if (op_go == bas_pkg::BAS_OP_NONE) begin
        st_q <= bas_pkg::BAS_ST_PAD;
      end else if (op_go >= bas_pkg::BAS_BLOCK_MOVE) begin
        if (cnt_q == 16'h0000) begin
          st_q <= bas_pkg::BAS_ST_PAD;
        end else if (op_go == bas_pkg::BAS_BLOCK_FILL) begin
          st_q <= bas_pkg::BAS_ST_WR;
        end else begin
          st_q <= bas_pkg::BAS_ST_RD;
        end
      end else begin
        st_q <= bas_pkg::BAS_ST_RD;
      end
    end else if (adv) begin
      case (st_q)
        bas_pkg::BAS_ST_RD: begin
          data_q <= mem_rdata;
          if (is_srch) begin
            st_q <= bas_pkg::BAS_ST_EL;
          end else if (is_str) begin
            st_q <= bas_pkg::BAS_ST_WR;
          end else begin
            st_q <= bas_pkg::BAS_ST_EXE;
          end
        end
        bas_pkg::BAS_ST_EXE: begin
          st_q <= bas_pkg::BAS_ST_PAD;
          case (op_q)
            bas_pkg::BAS_BIT_MOVE_ST: begin
              data_q <= {8'h00, acc_q[0] ? (data_q[7:0] | bit_mask)
                                        : (data_q[7:0] & ~bit_mask)};
              st_q <= bas_pkg::BAS_ST_WR;
            end
            bas_pkg::BAS_BIT_SET_OP: begin
              data_q <= {8'h00, data_q[7:0] | bit_mask};
              st_q <= bas_pkg::BAS_ST_WR;
            end
            bas_pkg::BAS_BIT_CLEAR_OP: begin
              data_q <= {8'h00, data_q[7:0] & ~bit_mask};
              st_q <= bas_pkg::BAS_ST_WR;
            end
            bas_pkg::BAS_BRANCH_ON_BIT_LOW: branch_q <= !bit_val;
            bas_pkg::BAS_BRANCH_ON_BIT_HIGH: branch_q <= bit_val;
            bas_pkg::BAS_TEST_AND_SET_BRANCH: begin
              branch_q <= bit_val;
              data_q <= {8'h00, data_q[7:0] | bit_mask};
              st_q <= bas_pkg::BAS_ST_WR;
            end
            bas_pkg::BAS_WAIT_BIT_HIGH: begin
              if (!bit_val) begin
                st_q <= bas_pkg::BAS_ST_RD;
              end
            end
            bas_pkg::BAS_WAIT_BIT_LOW: begin
              if (bit_val) begin
                st_q <= bas_pkg::BAS_ST_RD;
              end
            end
            default: st_q <= bas_pkg::BAS_ST_PAD;
          endcase
        end
        bas_pkg::BAS_ST_WR: begin
          st_q <= is_str ? bas_pkg::BAS_ST_EL : bas_pkg::BAS_ST_PAD;
        end
        bas_pkg::BAS_ST_EL: begin
          n_q <= n_q + 16'h0001;
          if (is_srch && hit) begin
            match_q <= 1'b1;
            st_q <= bas_pkg::BAS_ST_PAD;
          end else if (cnt_last) begin
            st_q <= bas_pkg::BAS_ST_PAD;
          end else if (op_q == bas_pkg::BAS_BLOCK_FILL) begin
            st_q <= bas_pkg::BAS_ST_WR;
          end else begin
            st_q <= bas_pkg::BAS_ST_RD;
          end
        end
        bas_pkg::BAS_ST_PAD: begin
          if (cyc_q + 20'h00001 >= target) begin
            st_q <= bas_pkg::BAS_ST_IDLE;
          end
        end
        default: st_q <= bas_pkg::BAS_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // architectural registers
  // ---------------------------------------------------------------
  logic in_exe;
  logic in_el;

  assign in_exe = adv && (st_q == bas_pkg::BAS_ST_EXE);
  assign in_el = adv && (st_q == bas_pkg::BAS_ST_EL);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q <= `BAS_ACC_RST;
    end else if (in_exe && op_q == bas_pkg::BAS_BIT_MOVE_LD) begin
      acc_q <= {acc_q[15:0], 15'h0000, bit_val};
    end else if (in_exe && op_q == bas_pkg::BAS_ACC_HALF_EXCHANGE) begin
      acc_q <= {acc_q[15:0], acc_q[31:16]};
    end else if (in_el && !(is_srch && hit)) begin
      if (is_down) begin
        acc_q <= {ah - step, is_srch ? al : al - step};
      end else begin
        acc_q <= {ah + step, (is_srch || op_q == bas_pkg::BAS_BLOCK_FILL) ? al
                             : al + step};
      end
    end else if (sw_wr_acc && !busy) begin
      acc_q <= hwdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= `BAS_CNT_RST;
    end else if (in_el && !(is_srch && hit)) begin
      cnt_q <= cnt_q - 16'h0001;
    end else if (sw_wr_cnt && !busy) begin
      cnt_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc_q <= `BAS_PC_RST;
    end else if (busy && st_q == bas_pkg::BAS_ST_PAD && branch_q && adv
                 && cyc_q + 20'h00001 >= target) begin
      pc_q <= pc_q + {{8{oper_q[31]}}, oper_q[31:`BAS_OPER_REL_LSB]};
    end else if (sw_wr_pc && !busy) begin
      pc_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else if (start && op_go == bas_pkg::BAS_BLOCK_FILL) begin
      flags_q.n <= hwdata[`BAS_CTRL_WORD] ? al[15] : al[7];
      flags_q.z <= hwdata[`BAS_CTRL_WORD] ? (al == 16'h0000) : (al[7:0] == 8'h00);
    end else if (in_exe) begin
      case (op_q)
        bas_pkg::BAS_BIT_MOVE_LD: begin
          flags_q.n <= 1'b0;
          flags_q.z <= !bit_val;
        end
        bas_pkg::BAS_BIT_MOVE_ST: begin
          flags_q.n <= 1'b0;
          flags_q.z <= !acc_q[0];
        end
        bas_pkg::BAS_BRANCH_ON_BIT_LOW, bas_pkg::BAS_BRANCH_ON_BIT_HIGH,
        bas_pkg::BAS_TEST_AND_SET_BRANCH: flags_q.z <= !bit_val;
        default: flags_q <= flags_q;
      endcase
    end else if (in_el && is_srch) begin
      flags_q.n <= diff[msb];
      flags_q.z <= hit;
      flags_q.v <= (elem_a[msb] ^ elem_b[msb]) & (elem_a[msb] ^ diff[msb]);
      flags_q.c <= word_q ? diff[16] : diff[8];
    end else if (sw_wr_flag && !busy) begin
      flags_q <= bas_pkg::bas_flags_t'(hwdata[3:0]);
    end
  end

endmodule : bas_exec

`default_nettype wire

// ===== bas_exec_asserts.sv
// bas_exec_asserts.sv: port checks of the bit/string unit
// assumes: bound to bas_exec, MCLK_DIV of 1
`timescale 1ns/1ps
`default_nettype none

module bas_exec_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire bas_pkg::bas_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // bus steps
  // ----
  sequence start_s;
    hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00 && !busy ##1 hwdata[0];
  endsequence
  sequence swap_s;
    start_s ##0 hwdata[4:1] == 4'h9;
  endsequence
  bus_answer_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not okay");
  unmapped_zero_a: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr[7:2] > 6'h07 |=> hrdata == 32'h0) else $error("unmapped read not zero");
  start_busy_a: assert property (start_s |=> busy) else $error("start ignored");
  swap_len_a: assert property (swap_s |=> busy ##[1:3] !busy)
    else $error("exchange length wrong");
  swap_quiet_a: assert property (swap_s |=> !mem_req.req [*3])
    else $error("exchange touched memory");
  req_hold_a: assert property (mem_req.req && !mem_ack |=> $stable(mem_req))
    else $error("request moved before answer");
  idle_noreq_a: assert property (!busy |-> !mem_req.req)
    else $error("request while idle");
  io_addr_a: assert property (mem_req.req && mem_req.io |-> mem_req.addr[15:8] == 8'h00)
    else $error("io address out of page");
endmodule : bas_exec_asserts

bind bas_exec bas_exec_asserts chk_u (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .mem_req, .mem_ack, .busy);

`default_nettype wire

// ===== bas_mem_model.sv
// bas_mem_model.sv: memory and I/O space answering the unit's port
// assumes: one clock; slow adds two wait cycles per access
`timescale 1ns/1ps
`default_nettype none

module bas_mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire bas_pkg::bas_mem_req_t mem_req,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_q = 2'h0;
  logic [15:0] a;
  assign a = mem_req.addr;
  initial mem_rdata = 16'h5A5A;
  // idle data toggles so a stale read shows
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req.req && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
      if (!slow || wait_q == 2'h2) begin
        wait_q <= 2'h0;
        mem_ack <= 1'b1;
        mem_rdata <= {mem_req.word ? mem[a + 16'h1] : 8'h00, mem[a]};
        if (mem_req.we) mem[a] <= mem_req.wdata[7:0];
        if (mem_req.we && mem_req.word) mem[a + 16'h1] <= mem_req.wdata[15:8];
      end
    end
  end
endmodule : bas_mem_model

`default_nettype wire

// ===== bit_accum_string_ops_tb.sv
// bit_accum_string_ops_tb.sv: self-checking bench of the bit/string unit
// assumes: bas_pkg, bas_exec, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none

module bit_accum_string_ops_tb;
  logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, mem_ack, busy, slow, wd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, lf;
  logic [15:0] mem_rdata;
  bas_pkg::bas_mem_req_t mem_req;
  int bad_count, comparisons;

  bas_exec dut_u (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .mem_req, .mem_ack, .mem_rdata, .busy);
  bas_mem_model mem_u (.ref_clk, .slow, .mem_req, .mem_ack, .mem_rdata);
  assign hready = hreadyout;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] ecyc(input logic [3:0] op, input logic io, input logic b);
    case (op)
      4'h0: return io ? 32'h4 : 32'h5;
      4'h1: return io ? 32'h6 : 32'h7;
      4'h4: return 32'(io ? 6 : 7) + 32'(!b);
      4'h5: return 32'(io ? 6 : 7) + 32'(b);
      4'h6: return b ? 32'hA : 32'h9;
      default: return 32'h7;
    endcase
  endfunction : ecyc

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic run(input logic [3:0] op, input logic [1:0] fm, input logic [31:0] oper,
      input logic [31:0] acc, input logic [15:0] cnt, input logic [3:0] fl);
    slow <= lf[2];
    bus(1'b1, 8'h04, oper);
    bus(1'b1, 8'h08, acc);
    bus(1'b1, 8'h0C, {16'h0, cnt});
    bus(1'b1, 8'h10, {28'h0, fl});
    bus(1'b1, 8'h00, {24'h0, wd, fm, op, 1'b1});
    do @(negedge ref_clk); while (busy === 1'b1);
    @(posedge ref_clk);
  endtask : run

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  initial begin
    logic [7:0] bv, eb;
    logic [3:0] op, fl, ef;
    logic [15:0] ad, pc;
    logic [2:0] bp;
    logic io;
    int m, s;
    lf = 32'hAC87;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    slow = 1'b0;
    wd = 1'b0;
    pc = 16'h0000;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    run(4'h9, 2'h0, 32'h0, lf, 16'h0, lf[3:0]);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, {lf[15:0], lf[31:16]});
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, {28'h0, lf[3:0]});
    $display("test reset and exchange done");
    // ----
    // bit operations, random byte, bit and flags
    // ----
    for (int i = 0; i < 28; i++) begin
      lf = lfsr(lf);
      op = 4'(i % 7);
      io = (i / 7) % 2 == 1 && op != 4'h6;
      ad = io ? {8'h00, lf[7:0]} : lf[15:0];
      bp = lf[18:16];
      fl = lf[23:20];
      bv = lf[31:24];
      mem_u.mem[ad] = bv;
      run(op, op == 4'h6 ? 2'h1 : {io, 1'b0}, {bv, 5'h0, bp, lf[15:0]}, lf, 16'h0, fl);
      eb = bv;
      if (op inside {4'h1, 4'h2, 4'h3, 4'h6}) eb[bp] = op == 4'h1 ? lf[0] : op != 4'h3;
      ef = fl;
      if (op < 4'h2) ef[3] = 1'b0;
      if (op < 4'h2 || op > 4'h3) ef[2] = op == 4'h1 ? !lf[0] : !bv[bp];
      chk({24'h0, mem_u.mem[ad]}, {24'h0, eb});
      bus(1'b0, 8'h1C, 32'h0);
      chk(rd, ecyc(op, io, bv[bp]));
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, {28'h0, ef});
      bus(1'b0, 8'h08, 32'h0);
      if (op == 4'h0) chk(rd, {lf[15:0], 15'h0, bv[bp]});
      if (op == 4'h4 ? !bv[bp] : (op inside {4'h5, 4'h6} && bv[bp])) pc += {{8{bv[7]}}, bv};
      bus(1'b0, 8'h14, 32'h0);
      chk(rd, {16'h0, pc});
    end
    $display("test bit operations done");
    // ----
    // block move, move down and fill
    // ----
    for (int j = 0; j < 6; j++) begin
      lf = lfsr(lf);
      op = j < 2 ? 4'hA : (j < 4 ? 4'hB : 4'hE);
      m = j % 2 == 1 ? int'(lf[1:0]) + 1 : 0;
      s = op == 4'hB ? -1 : 1;
      for (int k = 0; k < 4; k++) begin
        mem_u.mem[16'(32'h1040 + s * k)] = lf[7:0] + 8'(k);
        mem_u.mem[16'(32'h2040 + s * k)] = ~lf[7:0];
      end
      run(op, 2'h0, 32'h0, 32'h2040_1040, 16'(m), 4'h0);
      for (int k = 0; k < 4; k++) begin
        eb = k >= m ? ~lf[7:0] : (op == 4'hE ? 8'h40 : lf[7:0] + 8'(k));
        chk({24'h0, mem_u.mem[16'(32'h2040 + s * k)]}, {24'h0, eb});
      end
      bus(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'(op == 4'hE ? 6 * m + 6 : (m == 0 ? 5 : 4 + 8 * m)));
      bus(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, {16'(32'h2040 + s * m), 16'h1040 + 16'(op == 4'hE ? 0 : s * m)});
    end
    $display("test block move and fill done");
    mem_u.mem[16'h2040] = 8'h11;
    mem_u.mem[16'h2041] = 8'h22;
    mem_u.mem[16'h2042] = 8'h40;
    run(4'hC, 2'h0, 32'h0, 32'h2040_1040, 16'h4, 4'hB);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'd26);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h4);
    $display("test block search done");
    wd = 1'b1;
    {mem_u.mem[16'h2043], mem_u.mem[16'h2042]} = 16'h1234;
    {mem_u.mem[16'h2041], mem_u.mem[16'h2040]} = 16'h8000;
    run(4'hD, 2'h0, 32'h0, 32'h2042_1235, 16'h2, 4'h0);
    wd = 1'b0;
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'd18);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h203E_1235);
    for (int w = 0; w < 2; w++) begin
      mem_u.mem[16'h0033] = 8'(w * 32);
      fork
        run(4'(7 + w), 2'h2, 32'h0005_0033, 32'h0, 16'h0, 4'h5);
        begin
          repeat (40) @(negedge ref_clk);
          chk({31'h0, busy}, 32'h1);
          mem_u.mem[16'h0033] = 8'(32 - w * 32);
        end
      join
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h5);
    end
    $display("test word search and wait done");
    summarize();
  end
endmodule : bit_accum_string_ops_tb

`default_nettype wire
